// ==== verilog/duc_pkg.sv ====
// Purpose: shared constants and types for the dac update control block
// Assumes: pclk at 10 MHz, apb with 8-bit byte addresses
// Notes:   register offsets are byte addresses, one word each
package duc_pkg;
    localparam int NCH           = 32;
    localparam int CLK_NS        = 100;
    localparam int STAGE_NS      = 600;
    localparam int FINAL_NS      = 300;
    localparam int TOGGLE_NS     = 500;
    localparam int RESET_SEQ_US  = 300;

    // cycle counts, least times rounded up
    localparam logic [3:0]  STAGE_CYC     = 4'((STAGE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  FINAL_CYC     = 4'((FINAL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0]  TOGGLE_CYC    = 4'((TOGGLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] RESET_SEQ_CYC = 12'((RESET_SEQ_US * 1000) / CLK_NS);

    // register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RDSEL  = 8'h0C;
    localparam logic [7:0] OFS_RDOUT  = 8'h10;
    localparam logic [7:0] OFS_RDX2   = 8'h14;
    localparam logic [7:0] OFS_TSEL0  = 8'h20;
    localparam logic [7:0] OFS_TSEL3  = 8'h2C;

    // control and status bit positions
    localparam int CTRL_PD_BIT       = 0;
    localparam int CTRL_THERM_EN_BIT = 1;
    localparam int CTRL_AB_BIT       = 2;
    localparam int CTRL_THERM_FL_BIT = 4;
    localparam int ST_BUSY_LOCAL_BIT = 0;
    localparam int ST_BUSY_LINE_BIT  = 1;
    localparam int ST_LOAD_PEND_BIT  = 2;
    localparam int ST_RST_SEQ_BIT    = 3;
    localparam int ST_GROUNDED_BIT   = 4;
    localparam int CMD_WIDTH         = 25;

    // reset values
    localparam logic [15:0] X1_DEFAULT     = 16'h5554;
    localparam logic [15:0] GAIN_DEFAULT   = 16'hFFFF;
    localparam logic [15:0] OFFSET_DEFAULT = 16'h8000;
    localparam logic [15:0] CODE_DEFAULT   = 16'h5554;
    localparam logic [7:0]  TSEL_DEFAULT   = 8'h00;

    typedef enum logic [1:0] {
        MODE_SPECIAL = 2'h0,
        MODE_GAIN    = 2'h1,
        MODE_OFFSET  = 2'h2,
        MODE_DATA    = 2'h3
    } duc_mode_e;

    localparam logic [1:0] SCOPE_ONE   = 2'h0;
    localparam logic [1:0] SCOPE_SAME4 = 2'h1;
    localparam logic [1:0] SCOPE_GRP8  = 2'h2;

    // command word in pwdata[24:0]
    typedef struct packed {
        duc_mode_e   mode;
        logic [1:0]  scope;
        logic [4:0]  chan;
        logic [15:0] data;
    } duc_cmd_s;

    // asynchronous pins, synchronised together
    typedef struct packed {
        logic reset_n;
        logic clear_n;
        logic load_n;
        logic busy_n;
        logic over_temp;
    } duc_pins_s;
endpackage : duc_pkg

// ==== verilog/duc_busy_timer.sv ====
// Purpose: busy pulse timing for the shared multiplier and toggle writes
// Assumes: work_pending and work_more come from pclk logic
// Notes:   one step pulse per channel stage
`timescale 1ns/1ps
module duc_busy_timer (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // requests
    input  wire logic work_pending,
    input  wire logic work_more,
    input  wire logic toggle_start,
    // status
    output logic      step,
    output logic      busy
);
    import duc_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_STAGE, ST_TAIL, ST_FINAL, ST_TOGGLE} duc_tstate_e;

    duc_tstate_e state_q, state_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        tog_q, tog_d;
    wire         cnt_zero = (cnt_q == 4'h0);

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_zero ? 4'h0 : cnt_q - 4'h1;
        step    = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (work_pending)
                begin
                    state_d = ST_STAGE;
                    cnt_d   = STAGE_CYC - 4'h1;
                end
                else if (tog_q)
                begin
                    state_d = ST_TOGGLE;
                    cnt_d   = TOGGLE_CYC - 4'h1;
                end
            end
            ST_STAGE:
            begin
                if (cnt_zero)
                begin
                    step    = 1'b1;
                    state_d = work_more ? ST_STAGE : ST_TAIL;
                    cnt_d   = STAGE_CYC - 4'h1;
                end
            end
            ST_TAIL:
            begin
                if (work_pending)
                begin
                    state_d = ST_STAGE;
                    cnt_d   = STAGE_CYC - 4'h1;
                end
                else if (cnt_zero)
                begin
                    state_d = ST_FINAL;
                    cnt_d   = FINAL_CYC - 4'h1;
                end
            end
            ST_FINAL:
            begin
                if (work_pending)
                begin
                    state_d = ST_STAGE;
                    cnt_d   = STAGE_CYC - 4'h1;
                end
                else if (cnt_zero)
                    state_d = ST_IDLE;
            end
            ST_TOGGLE:
            begin
                if (cnt_zero)
                    state_d = ST_IDLE;
            end
        endcase
    end

    assign tog_d = toggle_start | (tog_q & ~(state_q == ST_IDLE && !work_pending));
    assign busy  = (state_q != ST_IDLE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            tog_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            tog_q   <= tog_d;
        end
    end

    a_toggle_width: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && tog_q && !work_pending) |=> busy[*5])
        else $error("toggle busy shorter than 500 ns");
    a_stage_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        step |=> !step[*5])
        else $error("channel stages closer than 600 ns");
    a_final_release: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_FINAL && cnt_zero && !work_pending && !tog_q && !toggle_start)
        |=> !busy)
        else $error("busy not released after final stage");
endmodule : duc_busy_timer

// ==== verilog/duc_update_ctrl.sv ====
// Purpose: dac update control: reset sequence, clear, busy, load, toggle
// Assumes: apb slave on pclk, zero wait states, pins are asynchronous
// Notes:   output codes and ground flag come from flops
//
// Overview of operation
// - reset pin rising edge restores all data, gain, offset defaults.
// - ground flag set in reset, clears next cycle unless clear low, power-down or thermal flag.
// - only the reset rising edge acts; host pulses low at least 30 ns.
// - clear low grounds outputs, ignores load strobes, keeps registers.
// - each input, gain or offset write starts recalculation with busy low.
// - writes are still accepted while busy, but outputs never update.
// - busy is wired-shared; another device holding it low delays load.
// - load falling edge during busy is stored, acted on once busy ends.
// - load held low updates outputs every time busy returns high.
// - toggle select writes drive busy low for about 500 ns.
// - channels computed in turn; busy lasts (n+1)*600 ns plus 300 ns.
// - busy pulse bounded by 1.5, 3.3, 5.7, 20.1 us.
// - a channel output updates only if its computed value or its select bank was written.
// - output takes computed A or B by the channel's select bit.
// - power-down bit grounds outputs, keeps registers, restores on clear.
// - thermal enable plus over-temperature forces shutdown and sets flag.
// - thermal shutdown holds until the thermal enable bit is cleared.
// - each channel holds computed A and B, fed by input A and B.
// - four 8-bit select banks map bits to channels 8n to 8n+7.
// - one bank write changes the source of all eight channels.
// - data writes go to input A when control A/B bit is 0, else B.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module duc_update_ctrl (
    // apb
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic [31:0]                       prdata,
    // device pins
    input  wire duc_pkg::duc_pins_s           pins,
    output logic                              busy_o,
    output logic                              busy_oe_n,
    // converter side
    output logic [duc_pkg::NCH-1:0][15:0]     out_code,
    output logic                              output_grounded
);
    import duc_pkg::*;

    function automatic logic [15:0] duc_calc(input logic [15:0] x,
                                             input logic [15:0] m,
                                             input logic [15:0] c);
        logic [32:0] prod;
        logic [17:0] sum;
        prod = 33'(x) * 33'({1'b0, m} + 17'h00001);
        sum  = {1'b0, prod[32:16]} + {2'h0, c};
        if (sum < 18'h08000)
            return 16'h0000;
        else if (sum > 18'h17FFF)
            return 16'hFFFF;
        else
            return 16'(sum - 18'h08000);
    endfunction : duc_calc

    function automatic logic [31:0] duc_mask(input logic [1:0] scope,
                                             input logic [4:0] chan);
        logic [31:0] m;
        m = 32'h0000_0000;
        unique case (scope)
            SCOPE_ONE:   m[chan] = 1'b1;
            SCOPE_SAME4: for (int k = 0; k < 4; k++) m[{2'(k), chan[2:0]}] = 1'b1;
            SCOPE_GRP8:  m[{chan[4:3], 3'h0} +: 8] = 8'hFF;
            default:     m = 32'hFFFF_FFFF;
        endcase
        return m;
    endfunction : duc_mask

    function automatic logic [4:0] duc_first(input logic [31:0] m);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NCH - 1; i >= 0; i--)
            if (m[i])
                idx = 5'(i);
        return idx;
    endfunction : duc_first

    // pin synchronisers
    duc_pins_s   sync1_q, sync2_q;
    logic        rst_pin_prev_q, load_prev_q, busy_line_prev_q;
    logic        busy_line;
    logic [11:0] rst_cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q          <= '{reset_n: 1'b1, clear_n: 1'b1, load_n: 1'b1,
                                  busy_n: 1'b1, over_temp: 1'b0};
            sync2_q          <= '{reset_n: 1'b1, clear_n: 1'b1, load_n: 1'b1,
                                  busy_n: 1'b1, over_temp: 1'b0};
            rst_pin_prev_q   <= 1'b1;
            load_prev_q      <= 1'b1;
            busy_line_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q          <= pins;
            sync2_q          <= sync1_q;
            rst_pin_prev_q   <= sync2_q.reset_n;
            load_prev_q      <= sync2_q.load_n;
            busy_line_prev_q <= busy_line;
        end
    end

    wire clear_s   = sync2_q.clear_n;
    wire load_s    = sync2_q.load_n;
    wire rst_rise  = sync2_q.reset_n & ~rst_pin_prev_q;
    wire load_fall = load_prev_q & ~load_s;
    wire rst_seq   = (rst_cnt_q != 12'h000);

    // apb decode
    wire       setup    = psel & ~penable;
    wire       access   = psel & penable;
    wire       wr       = access & pwrite;
    wire       hit_ctrl = (paddr == OFS_CTRL);
    wire       hit_cmd  = (paddr == OFS_CMD);
    wire       hit_rsel = (paddr == OFS_RDSEL);
    wire       hit_tsel = (paddr >= OFS_TSEL0) && (paddr <= OFS_TSEL3) && (paddr[1:0] == 2'h0);
    wire       mapped   = hit_ctrl | hit_cmd | hit_rsel | hit_tsel | (paddr == OFS_STATUS)
                          | (paddr == OFS_RDOUT) | (paddr == OFS_RDX2);
    wire       refuse   = wr & rst_seq;
    wire       wr_ok    = wr & mapped & ~rst_seq;
    wire       cmd_wr   = wr_ok & hit_cmd;
    wire       ctrl_wr  = wr_ok & hit_ctrl;
    wire       tsel_wr  = wr_ok & hit_tsel;
    wire [1:0] bank     = paddr[3:2];
    duc_cmd_s  cmd;

    assign cmd     = duc_cmd_s'(pwdata[CMD_WIDTH-1:0]);
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | refuse);

    // register storage
    logic [15:0]      x1a_q [NCH];
    logic [15:0]      x1b_q [NCH];
    logic [15:0]      gain_q [NCH];
    logic [15:0]      ofs_q [NCH];
    logic [15:0]      x2a_q [NCH];
    logic [15:0]      x2b_q [NCH];
    logic [NCH-1:0]   work_q, job_b_q, changed_q;
    logic [3:0][7:0]  tsel_q;
    logic             pd_q, therm_en_q, ab_q, therm_fl_q, load_pend_q, grounded_q;
    logic [4:0]       rsel_q;
    logic [31:0]      prdata_q;

    // busy timing and wired line
    logic        step, busy_local;
    wire  [31:0] cmd_mask  = (cmd_wr && cmd.mode != MODE_SPECIAL) ? duc_mask(cmd.scope, cmd.chan)
                                                                   : 32'h0000_0000;
    wire  [31:0] work_left = work_q & (work_q - 32'h0000_0001);
    wire  [4:0]  step_ch   = duc_first(work_q);
    wire  [15:0] step_code = duc_calc(job_b_q[step_ch] ? x1b_q[step_ch] : x1a_q[step_ch],
                                      gain_q[step_ch], ofs_q[step_ch]);
    assign busy_line = busy_local | ~sync2_q.busy_n;
    wire         busy_done = busy_line_prev_q & ~busy_line;
    wire         do_update = load_pend_q & ~busy_line & clear_s;
    wire  [31:0] step_bit  = step ? (32'h0000_0001 << step_ch) : 32'h0000_0000;
    wire  [31:0] tsel_bits = tsel_wr ? (32'h0000_00FF << {bank, 3'h0}) : 32'h0000_0000;

    duc_busy_timer u_timer (
        .pclk         (pclk),
        .presetn      (presetn),
        .work_pending (work_q != 32'h0000_0000),
        .work_more    (work_left != 32'h0000_0000),
        .toggle_start (tsel_wr),
        .step         (step),
        .busy         (busy_local)
    );

    assign busy_o    = 1'b0;
    assign busy_oe_n = ~busy_local;

    // input, gain, offset and computed registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                x1a_q[i]  <= X1_DEFAULT;
                x1b_q[i]  <= X1_DEFAULT;
                gain_q[i] <= GAIN_DEFAULT;
                ofs_q[i]  <= OFFSET_DEFAULT;
                x2a_q[i]  <= CODE_DEFAULT;
                x2b_q[i]  <= CODE_DEFAULT;
            end
        end
        else if (rst_rise)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                x1a_q[i]  <= X1_DEFAULT;
                x1b_q[i]  <= X1_DEFAULT;
                gain_q[i] <= GAIN_DEFAULT;
                ofs_q[i]  <= OFFSET_DEFAULT;
                x2a_q[i]  <= CODE_DEFAULT;
                x2b_q[i]  <= CODE_DEFAULT;
            end
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
                if (cmd_mask[i])
                begin
                    if (cmd.mode == MODE_DATA && !ab_q)
                        x1a_q[i] <= cmd.data;
                    if (cmd.mode == MODE_DATA && ab_q)
                        x1b_q[i] <= cmd.data;
                    if (cmd.mode == MODE_GAIN)
                        gain_q[i] <= cmd.data;
                    if (cmd.mode == MODE_OFFSET)
                        ofs_q[i] <= cmd.data;
                end
            if (step && !job_b_q[step_ch])
                x2a_q[step_ch] <= step_code;
            if (step && job_b_q[step_ch])
                x2b_q[step_ch] <= step_code;
        end
    end

    // outputs: update only changed channels, from selected source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            for (int i = 0; i < NCH; i++)
                out_code[i] <= CODE_DEFAULT;
        else if (rst_rise)
            for (int i = 0; i < NCH; i++)
                out_code[i] <= CODE_DEFAULT;
        else if (do_update)
            for (int i = 0; i < NCH; i++)
                if (changed_q[i])
                    out_code[i] <= tsel_q[i / 8][i % 8] ? x2b_q[i] : x2a_q[i];
    end

    // control state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_q   <= 12'h000;
            work_q      <= '0;
            job_b_q     <= '0;
            changed_q   <= '0;
            tsel_q      <= {4{TSEL_DEFAULT}};
            pd_q        <= 1'b0;
            therm_en_q  <= 1'b0;
            ab_q        <= 1'b0;
            therm_fl_q  <= 1'b0;
            load_pend_q <= 1'b0;
            grounded_q  <= 1'b1;
            rsel_q      <= 5'h00;
        end
        else
        begin
            rst_cnt_q   <= rst_rise ? RESET_SEQ_CYC : (rst_seq ? rst_cnt_q - 12'h001 : 12'h000);
            work_q      <= rst_rise ? '0 : ((work_q & ~step_bit) | cmd_mask);
            job_b_q     <= ab_q ? (job_b_q | cmd_mask) : (job_b_q & ~cmd_mask);
            changed_q   <= rst_rise ? '0
                         : ((changed_q & ~{NCH{do_update}}) | step_bit | tsel_bits);
            if (tsel_wr)
                tsel_q[bank] <= pwdata[7:0];
            if (ctrl_wr)
            begin
                pd_q       <= pwdata[CTRL_PD_BIT];
                therm_en_q <= pwdata[CTRL_THERM_EN_BIT];
                ab_q       <= pwdata[CTRL_AB_BIT];
            end
            therm_fl_q  <= therm_en_q & (therm_fl_q | sync2_q.over_temp);
            load_pend_q <= clear_s & ((load_pend_q & ~do_update) | load_fall
                                      | (busy_done & ~load_s));
            grounded_q  <= ~clear_s | pd_q | therm_fl_q;
            if (wr_ok && hit_rsel)
                rsel_q <= pwdata[4:0];
        end
    end

    assign output_grounded = grounded_q;

    // read data captured in setup phase
    wire [31:0] status_w = (32'(busy_local) << ST_BUSY_LOCAL_BIT)
                         | (32'(busy_line) << ST_BUSY_LINE_BIT)
                         | (32'(load_pend_q) << ST_LOAD_PEND_BIT)
                         | (32'(rst_seq) << ST_RST_SEQ_BIT)
                         | (32'(grounded_q) << ST_GROUNDED_BIT);
    wire [31:0] ctrl_w   = (32'(pd_q) << CTRL_PD_BIT) | (32'(therm_en_q) << CTRL_THERM_EN_BIT)
                         | (32'(ab_q) << CTRL_AB_BIT) | (32'(therm_fl_q) << CTRL_THERM_FL_BIT);
    wire [31:0] rd_w     = hit_ctrl            ? ctrl_w
                         : (paddr == OFS_STATUS) ? status_w
                         : hit_rsel            ? {27'h0000000, rsel_q}
                         : (paddr == OFS_RDOUT)  ? {16'h0000, out_code[rsel_q]}
                         : (paddr == OFS_RDX2)   ? {x2b_q[rsel_q], x2a_q[rsel_q]}
                         : hit_tsel            ? {24'h000000, tsel_q[bank]}
                         : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (setup)
            prdata_q <= pwrite ? 32'h0000_0000 : rd_w;
    end

    assign prdata = prdata_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reset_defaults: assert property (rst_rise |=>
        (x1a_q[0] == X1_DEFAULT && gain_q[31] == GAIN_DEFAULT && ofs_q[5] == OFFSET_DEFAULT))
        else $error("reset edge did not restore defaults");
    a_clear_blocks_load: assert property (!clear_s |-> !do_update ##1 !load_pend_q)
        else $error("load acted while clear low");
    a_write_starts_busy: assert property (
        (cmd_wr && cmd.mode != MODE_SPECIAL && !busy_local) |-> ##2 busy_local)
        else $error("busy not raised after data write");
    a_busy_blocks_update: assert property (busy_line |-> !do_update)
        else $error("output update while busy");
    a_wired_busy: assert property (!sync2_q.busy_n |-> busy_line)
        else $error("external busy ignored");
    a_load_stored: assert property ((load_fall && busy_line && clear_s) |=> load_pend_q)
        else $error("load during busy lost");
    a_held_low_update: assert property (
        (busy_done && !load_s && clear_s) |=> (do_update || !clear_s || busy_line))
        else $error("held load did not update after busy");
    a_unchanged_kept: assert property (
        (do_update && !changed_q[0] && !rst_rise) |=> $stable(out_code[0]))
        else $error("unchanged channel updated");
    a_source_select: assert property ((do_update && changed_q[9]) |=>
        out_code[9] == ($past(tsel_q[1][1]) ? $past(x2b_q[9]) : $past(x2a_q[9])))
        else $error("output took wrong computed source");
    a_powerdown_ground: assert property (pd_q |=> grounded_q)
        else $error("power-down did not ground outputs");
    a_thermal_trip: assert property ((therm_en_q && sync2_q.over_temp) |=> therm_fl_q)
        else $error("thermal flag not set");
    a_thermal_hold: assert property ((therm_fl_q && therm_en_q) |=> therm_fl_q)
        else $error("thermal shutdown released early");

    c_load_in_busy: cover property (load_fall && busy_line ##[1:300] do_update);
    c_toggle_write: cover property (tsel_wr ##1 busy_local);
    c_thermal_trip: cover property ($rose(therm_fl_q));
endmodule : duc_update_ctrl

// ==== sim/duc_host_model.sv ====
// Purpose: host side pin model with the wired busy line
// Assumes: busy line pulled up, another device may hold it low
// Notes:   pin requests change at pclk edges
`timescale 1ns/1ps
module duc_host_model (
    // pin requests
    input  wire logic          reset_n,
    input  wire logic          clear_n,
    input  wire logic          load_n,
    input  wire logic          ext_busy,
    input  wire logic          over_temp,
    // wired busy line
    input  wire logic          busy_o,
    input  wire logic          busy_oe_n,
    output logic               busy_wire,
    output duc_pkg::duc_pins_s pins
);
    import duc_pkg::*;
    assign busy_wire = !busy_oe_n ? busy_o : !ext_busy;
    assign pins = duc_pins_s'{reset_n, clear_n, load_n, busy_wire, over_temp};
endmodule : duc_host_model

// ==== sim/tb_top.sv ====
// Purpose: apb sequences checking busy, load, clear, toggle and shutdown
// Assumes: zero wait state slave, unity gain and offset defaults
// Notes:   busy low cycles counted on the wired line
`timescale 1ns/1ps
module tb_top;
    import duc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic busy_o, busy_oe_n, grounded, rst_n, clr_n, ld_n, ext_busy, hot, bw;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NCH-1:0][15:0] out_code;
    duc_pins_s pins;
    int n_mismatch, comparisons, bcnt;
    duc_update_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .pslverr, .prdata, .pins, .busy_o, .busy_oe_n, .out_code,
        .output_grounded(grounded));
    duc_host_model host (.reset_n(rst_n), .clear_n(clr_n), .load_n(ld_n), .ext_busy,
        .over_temp(hot), .busy_o, .busy_oe_n, .busy_wire(bw), .pins);
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) if (bw === 1'b0) bcnt <= bcnt + 1;
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task ld;
        ld_n <= 1'b0; repeat (4) @(posedge pclk);
        ld_n <= 1'b1; repeat (8) @(posedge pclk);
    endtask : ld
    function automatic logic [31:0] cmd(input logic [4:0] c, input logic [15:0] d);
        return {7'h00, duc_cmd_s'{MODE_DATA, SCOPE_ONE, c, d}};
    endfunction : cmd
    task wrap_up;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (6000) @(posedge pclk);
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_busy, hot} = '0;
        {rst_n, clr_n, ld_n} = 3'h7; bcnt = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(0, OFS_TSEL0, 0); chk("tsel0", 32'h0, rd);
        chk("code0", 32'h5554, out_code[0]);
        apb(0, 8'h40, 0); chk("slverr", 32'h1, err);
        bcnt = 0; apb(1, OFS_CMD, cmd(0, 16'h1234)); repeat (25) @(posedge pclk);
        chk("busy1", 32'd15, bcnt);
        ld; chk("code0", 32'h1234, out_code[0]);
        chk("code1", 32'h5554, out_code[1]);
        apb(1, OFS_CMD, cmd(1, 16'h2222)); ld;
        chk("code1", 32'h5554, out_code[1]);
        repeat (10) @(posedge pclk); chk("code1", 32'h2222, out_code[1]);
        apb(1, OFS_CMD, cmd(2, 16'h3333)); repeat (20) @(posedge pclk);
        clr_n <= 1'b0;
        apb(1, OFS_CMD, {7'h00, duc_cmd_s'{MODE_OFFSET, SCOPE_ONE, 5'h02, OFFSET_DEFAULT}});
        repeat (5) @(posedge pclk); chk("gnd", 32'h1, grounded);
        ld; clr_n <= 1'b1; repeat (5) @(posedge pclk);
        chk("code2", 32'h5554, out_code[2]); chk("gnd", 32'h0, grounded);
        apb(1, OFS_CTRL, 4); apb(1, OFS_CMD, cmd(0, 16'h4321)); repeat (20) @(posedge pclk);
        bcnt = 0; apb(1, OFS_TSEL0, 1); repeat (12) @(posedge pclk);
        chk("busytog", 32'd5, bcnt);
        ext_busy <= 1'b1; ld; chk("code0", 32'h1234, out_code[0]);
        ext_busy <= 1'b0; repeat (5) @(posedge pclk);
        chk("code0", 32'h4321, out_code[0]);
        apb(1, OFS_CTRL, 1); repeat (4) @(posedge pclk); chk("gnd", 32'h1, grounded);
        apb(1, OFS_CTRL, 0); repeat (4) @(posedge pclk); chk("gnd", 32'h0, grounded);
        apb(1, OFS_CTRL, 2); hot <= 1'b1; repeat (6) @(posedge pclk);
        hot <= 1'b0; repeat (6) @(posedge pclk); apb(0, OFS_CTRL, 0);
        chk("tflag", 32'h1, rd[CTRL_THERM_FL_BIT]);
        chk("gnd", 32'h1, grounded);
        apb(1, OFS_CTRL, 0); repeat (4) @(posedge pclk); chk("gnd", 32'h0, grounded);
        ld_n <= 1'b0; apb(1, OFS_CMD, cmd(3, 16'h3C3C)); repeat (30) @(posedge pclk);
        chk("code3", 32'h3C3C, out_code[3]);
        ld_n <= 1'b1;
        rst_n <= 1'b0; repeat (4) @(posedge pclk); rst_n <= 1'b1; repeat (8) @(posedge pclk);
        chk("code0", 32'h5554, out_code[0]);
        apb(1, OFS_CTRL, 1); chk("rstwr", 32'h1, err);
        wrap_up;
    end
endmodule : tb_top
